// file: verilog/gyro_cfg.svh
`ifndef GYRO_CFG_SVH
`define GYRO_CFG_SVH

// ****************************************************************
// Device register offsets (7-bit register numbers)
// ****************************************************************
`define OFF_CONFIG        7'h1a
`define OFF_SOURCE_ENABLE 7'h23
`define OFF_INT_STATUS    7'h3a
`define OFF_SENSOR_FIRST  7'h41
`define OFF_SENSOR_LAST   7'h48
`define OFF_USER_CONTROL  7'h6a
`define OFF_POWER_CONTROL 7'h6b
`define OFF_AXIS_STANDBY  7'h6c
`define OFF_COUNT_HIGH    7'h72
`define OFF_COUNT_LOW     7'h73
`define OFF_DATA_PORT     7'h74
`define OFF_IDENTITY      7'h75

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define BIT_OVERFLOW_MODE 6
`define BIT_OVERFLOW_FLAG 4
`define BIT_FIFO_ENABLE   6
`define BIT_FIFO_RESET    2
`define BIT_SOFT_RESET    7
`define CLOCK_SOURCE_SELECT_MSB        2
`define STANDBY_MSB       2
`define COUNT_W           10
`define CLOCK_SOURCE_SELECT_RESET      3'h1
`define CLOCK_SOURCE_SELECT_OSC_A      3'h0
`define CLOCK_SOURCE_SELECT_OSC_B      3'h6
`define CLOCK_SOURCE_SELECT_RESERVED   3'h7
`define SENSOR_BYTES      8

// ****************************************************************
// Controller APB map
// ****************************************************************
`define APB_ADDR_W        12
`define APB_OFF_COMMAND   12'h000
`define APB_OFF_STATUS    12'h004
`define CMD_DATA_LSB      0
`define CMD_ADDR_LSB      8
`define CMD_WRITE_BIT     16
`define STAT_BUSY_BIT     0
`define STAT_DONE_BIT     1
`define STAT_DATA_LSB     8

`endif

// file: verilog/gyro_pkg.sv
`default_nettype none
package gyro_pkg;
   // Controller sequencer, one-hot
   typedef enum logic [1:0] {
      CTL_IDLE = 2'b01,
      CTL_WAIT = 2'b10
   } ctl_state_t;

   typedef logic [6:0] reg_addr_t;
   typedef logic [7:0] reg_byte_t;
endpackage
`default_nettype wire

// file: verilog/gyro_link_if.sv
`default_nettype none
// Register access link: request held until a one-cycle acknowledge
interface gyro_link_if;
   logic                 req;
   logic                 we;
   gyro_pkg::reg_addr_t  addr;
   gyro_pkg::reg_byte_t  wdata;
   logic                 ack;
   gyro_pkg::reg_byte_t  rdata;

   modport device (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host   (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// file: verilog/gyro_device.sv
// Implementation choice: the request/acknowledge link interface to the registers.
`include "gyro_cfg.svh"
`default_nettype none
module gyro_device #(
   parameter int         FIFO_DEPTH    = 512,
   parameter logic [5:0] IDENTITY_CODE = 6'h2a   // Arbitrary value
) (
   input  wire logic        CLOCK_I,
   input  wire logic        RESETN_I,
   gyro_link_if.device      LINK,
   input  wire logic        SAMPLE_TICK_I,
   input  wire logic [63:0] SENSOR_DATA_I,
   input  wire logic        ADDRESS_SELECT_PIN_I,
   output logic [2:0]       AXIS_STANDBY_O,
   output logic             DRIVE_ENABLE_O,
   output logic             PLL_CLOCK_SELECTED_O,
   output logic [6:0]       BUS_ADDRESS_O
);
   localparam int AW = $clog2(FIFO_DEPTH);
   // The count field is 10 bits, so a full queue must still fit in it
   if ((FIFO_DEPTH < 2) || (FIFO_DEPTH > 512) || ((1 << AW) != FIFO_DEPTH)) begin : g_bad_depth
      $error("FIFO_DEPTH must be a power of two from 2 to 512");
   end
   // ****************************************************************
   // State
   // ****************************************************************
   logic [`STANDBY_MSB:0]     standby_q;
   logic [`CLOCK_SOURCE_SELECT_MSB:0]      clock_source_select_q;
   logic                      fifo_enable_q;
   logic                      fifo_flush_q;
   logic                      soft_reset_q;
   logic [7:0]                source_enable_q;
   logic                      overflow_mode_q;
   logic                      queue_overflow_flag_q;
   logic [`COUNT_W-1:0]       count_shadow_q;
   logic [`COUNT_W-1:0]       level_q;
   logic [AW-1:0]             wr_ptr_q;
   logic [AW-1:0]             rd_ptr_q;
   logic [7:0]                mem [FIFO_DEPTH];
   logic [63:0]               snap_q;
   logic [7:0]                pend_q;
   logic                      ack_q;
   logic [7:0]                rdata_q;
   logic                      pin_meta_q;
   logic                      pin_sync_q;
   logic                      drive_q;
   logic                      pll_q;
   logic [6:0]                bus_addr_q;
   // ****************************************************************
   // Request decode
   // ****************************************************************
   // A request is taken once; the acknowledge cycle masks the held request
   wire        clr         = ~RESETN_I | soft_reset_q;
   wire        take        = LINK.req & ~ack_q;
   wire        wr          = take & LINK.we;
   wire        rd          = take & ~LINK.we;
   wire        hit_standby = LINK.addr == `OFF_AXIS_STANDBY;
   wire        hit_user    = LINK.addr == `OFF_USER_CONTROL;
   wire        hit_power   = LINK.addr == `OFF_POWER_CONTROL;
   wire        hit_source  = LINK.addr == `OFF_SOURCE_ENABLE;
   wire        hit_config  = LINK.addr == `OFF_CONFIG;
   wire        hit_status  = LINK.addr == `OFF_INT_STATUS;
   wire        hit_high    = LINK.addr == `OFF_COUNT_HIGH;
   wire        hit_data    = LINK.addr == `OFF_DATA_PORT;
   wire        hit_sensor  = (LINK.addr >= `OFF_SENSOR_FIRST) &&
                             (LINK.addr <= `OFF_SENSOR_LAST);
   wire [2:0]  sensor_idx  = 3'(LINK.addr - `OFF_SENSOR_FIRST);
   // Clock-select code 7 is reserved, so such writes keep the old code
   wire        clk_ok      = LINK.wdata[`CLOCK_SOURCE_SELECT_MSB:0] != `CLOCK_SOURCE_SELECT_RESERVED;
   // ****************************************************************
   // Queue datapath
   // ****************************************************************
   // Lowest pending source goes first, giving ascending register order
   logic [2:0] sel_idx;
   always_comb begin
      sel_idx = 3'h0;
      for (int i = `SENSOR_BYTES - 1; i >= 0; i--) begin
         if (pend_q[i]) begin
            sel_idx = 3'(i);
         end
      end
   end
   wire [`COUNT_W-1:0] depth_c   = `COUNT_W'(FIFO_DEPTH);
   wire        empty     = level_q == '0;
   wire        full      = level_q == depth_c;
   wire        host_push = wr & hit_data;
   wire        host_pop  = rd & hit_data & fifo_enable_q & ~empty;
   // Host pushes win the cycle; the sample walk simply waits one cycle
   wire        samp_push = (|pend_q) & ~host_push;
   wire        push      = host_push | samp_push;
   wire [7:0]  push_byte = host_push ? LINK.wdata : snap_q[sel_idx*8 +: 8];
   wire        overflow  = push & full & ~host_pop;
   wire        drop_new  = overflow & overflow_mode_q;
   wire        evict_old = overflow & ~overflow_mode_q;
   wire        do_write  = push & ~drop_new;
   wire        do_pop    = host_pop | evict_old;
   wire [7:0]  head_byte = mem[rd_ptr_q];
   // ****************************************************************
   // Read data selection
   // ****************************************************************
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      if (hit_standby) begin
         rd_mux = {5'h00, standby_q};
      end else if (hit_user) begin
         rd_mux = 8'(fifo_enable_q) << `BIT_FIFO_ENABLE;
      end else if (hit_power) begin
         rd_mux = {5'h00, clock_source_select_q};
      end else if (hit_source) begin
         rd_mux = source_enable_q;
      end else if (hit_config) begin
         rd_mux = 8'(overflow_mode_q) << `BIT_OVERFLOW_MODE;
      end else if (hit_status) begin
         rd_mux = 8'(queue_overflow_flag_q) << `BIT_OVERFLOW_FLAG;
      end else if (hit_high) begin
         rd_mux = {6'h00, level_q[`COUNT_W-1:8]};
      end else if (LINK.addr == `OFF_COUNT_LOW) begin
         rd_mux = count_shadow_q[7:0];
      end else if (hit_data) begin
         rd_mux = host_pop ? head_byte : 8'h00;
      end else if (LINK.addr == `OFF_IDENTITY) begin
         rd_mux = {1'b0, IDENTITY_CODE, 1'b0};
      end else if (hit_sensor) begin
         rd_mux = SENSOR_DATA_I[sensor_idx*8 +: 8];
      end
   end
   // Acknowledge one cycle after the take, read data beside it; soft reset pulses once
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         ack_q        <= 1'b0;
         rdata_q      <= 8'h00;
         soft_reset_q <= 1'b0;
      end else begin
         ack_q        <= take;
         rdata_q      <= rd ? rd_mux : rdata_q;
         soft_reset_q <= wr & hit_power & LINK.wdata[`BIT_SOFT_RESET];
      end
   end
   // ****************************************************************
   // Writable control registers
   // ****************************************************************
   // Count, identity and sensor registers have no write path at all
   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         standby_q             <= '0;
         clock_source_select_q <= `CLOCK_SOURCE_SELECT_RESET;
         fifo_enable_q         <= 1'b0;
         source_enable_q       <= 8'h00;
         overflow_mode_q       <= 1'b0;
         fifo_flush_q          <= 1'b0;
      end else begin
         fifo_flush_q <= wr & hit_user & LINK.wdata[`BIT_FIFO_RESET];
         if (wr & hit_standby) begin
            standby_q <= LINK.wdata[`STANDBY_MSB:0];
         end
         if (wr & hit_user) begin
            fifo_enable_q <= LINK.wdata[`BIT_FIFO_ENABLE];
         end
         if (wr & hit_power & clk_ok) begin
            clock_source_select_q <= LINK.wdata[`CLOCK_SOURCE_SELECT_MSB:0];
         end
         if (wr & hit_source) begin
            source_enable_q <= LINK.wdata;
         end
         if (wr & hit_config) begin
            overflow_mode_q <= LINK.wdata[`BIT_OVERFLOW_MODE];
         end
      end
   end
   // Read of the status register clears the flag; a new overflow wins
   always_ff @(posedge CLOCK_I) begin
      if (clr) begin
         queue_overflow_flag_q <= 1'b0;
         count_shadow_q        <= '0;
      end else begin
         if (overflow) begin
            queue_overflow_flag_q <= 1'b1;
         end else if (rd & hit_status) begin
            queue_overflow_flag_q <= 1'b0;
         end
         if (rd & hit_high) begin
            count_shadow_q <= level_q;
         end
      end
   end
   // ****************************************************************
   // Sample capture and queue pointers
   // ****************************************************************
   // A tick during an unfinished walk restarts it with the new sample
   always_ff @(posedge CLOCK_I) begin
      if (clr || fifo_flush_q) begin
         pend_q   <= 8'h00;
         snap_q   <= '0;
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         level_q  <= '0;
      end else begin
         if (SAMPLE_TICK_I) begin
            snap_q <= SENSOR_DATA_I;
            pend_q <= source_enable_q;
         end else if (samp_push) begin
            pend_q[sel_idx] <= 1'b0;
         end
         if (do_write) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
         end
         level_q <= level_q + `COUNT_W'(do_write & ~do_pop) - `COUNT_W'(do_pop & ~do_write);
      end
   end
   // Storage has no reset; pointers define what is valid
   always_ff @(posedge CLOCK_I) begin
      if (do_write) begin
         mem[wr_ptr_q] <= push_byte;
      end
   end
   // ****************************************************************
   // Pin synchroniser and system outputs
   // ****************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         pin_meta_q <= 1'b0;
         pin_sync_q <= 1'b0;
         drive_q    <= 1'b0;
         pll_q      <= 1'b0;
         bus_addr_q <= 7'h00;
      end else begin
         pin_meta_q <= ADDRESS_SELECT_PIN_I;
         pin_sync_q <= pin_meta_q;
         drive_q    <= ~&standby_q;
         pll_q      <= (clock_source_select_q != `CLOCK_SOURCE_SELECT_OSC_A) &&
                       (clock_source_select_q != `CLOCK_SOURCE_SELECT_OSC_B);
         bus_addr_q <= {IDENTITY_CODE, pin_sync_q};
      end
   end
   assign LINK.ack             = ack_q;
   assign LINK.rdata           = rdata_q;
   assign AXIS_STANDBY_O       = standby_q;
   assign DRIVE_ENABLE_O       = drive_q;
   assign PLL_CLOCK_SELECTED_O = pll_q;
   assign BUS_ADDRESS_O        = bus_addr_q;
endmodule
`default_nettype wire

// file: verilog/gyro_host.sv
`include "gyro_cfg.svh"
`default_nettype none
module gyro_host (
   input  wire logic                   CLOCK_I,
   input  wire logic                   RESETN_I,
   input  wire logic                   PSEL_I,
   input  wire logic                   PENABLE_I,
   input  wire logic                   PWRITE_I,
   input  wire logic [`APB_ADDR_W-1:0] PADDR_I,
   input  wire logic [31:0]            PWDATA_I,
   output logic      [31:0]            PRDATA_O,
   output logic                        PREADY_O,
   output logic                        PSLVERR_O,
   gyro_link_if.host                   LINK
);
   gyro_pkg::ctl_state_t state_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic [31:0]          prdata_q;
   logic                 req_q;
   logic                 we_q;
   logic [6:0]           addr_q;
   logic [7:0]           wdata_q;
   logic [7:0]           rdata_q;
   logic                 done_q;

   // ****************************************************************
   // APB decode
   // ****************************************************************
   // One wait state: pready rises the cycle after the access phase starts
   wire access   = PSEL_I & PENABLE_I & ~pready_q;
   wire finish   = PSEL_I & PENABLE_I & pready_q;
   wire hit_cmd  = PADDR_I == `APB_OFF_COMMAND;
   wire hit_stat = PADDR_I == `APB_OFF_STATUS;
   wire idle     = state_q == gyro_pkg::CTL_IDLE;
   // A command written while busy is dropped; software polls busy first
   wire start    = finish & PWRITE_I & hit_cmd & idle;
   wire clr_done = finish & PWRITE_I & hit_stat & PWDATA_I[`STAT_DONE_BIT];
   wire got_ack  = (state_q == gyro_pkg::CTL_WAIT) & LINK.ack;
   wire [31:0] cmd_word  = {15'h0000, we_q, 1'b0, addr_q, wdata_q};
   wire [31:0] stat_word = {16'h0000, rdata_q, 6'h00, done_q, ~idle};
   wire [31:0] rd_mux    = hit_cmd ? cmd_word : (hit_stat ? stat_word : 32'h0000_0000);

   // ****************************************************************
   // APB answer
   // ****************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= access;
         pslverr_q <= access & ~hit_cmd & ~hit_stat;
         prdata_q  <= (access & ~PWRITE_I) ? rd_mux : 32'h0000_0000;
      end
   end

   // ****************************************************************
   // Link sequencer
   // ****************************************************************
   // Request drops one edge after the acknowledge rises; the device masks it in the ack cycle
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         state_q <= gyro_pkg::CTL_IDLE;
         req_q   <= 1'b0;
         we_q    <= 1'b0;
         addr_q  <= 7'h00;
         wdata_q <= 8'h00;
         rdata_q <= 8'h00;
      end else begin
         unique case (state_q)
            gyro_pkg::CTL_IDLE: begin
               if (start) begin
                  req_q   <= 1'b1;
                  we_q    <= PWDATA_I[`CMD_WRITE_BIT];
                  addr_q  <= PWDATA_I[`CMD_ADDR_LSB +: 7];
                  wdata_q <= PWDATA_I[`CMD_DATA_LSB +: 8];
                  state_q <= gyro_pkg::CTL_WAIT;
               end
            end
            gyro_pkg::CTL_WAIT: begin
               if (LINK.ack) begin
                  req_q   <= 1'b0;
                  rdata_q <= we_q ? rdata_q : LINK.rdata;
                  state_q <= gyro_pkg::CTL_IDLE;
               end
            end
            default: begin
               req_q   <= 1'b0;
               state_q <= gyro_pkg::CTL_IDLE;
            end
         endcase
      end
   end

   // Done is sticky; completion wins over a clear in the same cycle
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         done_q <= 1'b0;
      end else if (got_ack) begin
         done_q <= 1'b1;
      end else if (clr_done || start) begin
         done_q <= 1'b0;
      end
   end

   assign PRDATA_O   = prdata_q;
   assign PREADY_O   = pready_q;
   assign PSLVERR_O  = pslverr_q;
   assign LINK.req   = req_q;
   assign LINK.we    = we_q;
   assign LINK.addr  = addr_q;
   assign LINK.wdata = wdata_q;
endmodule
`default_nettype wire

// file: sim/gyro_link_checker.sv
`default_nettype none
// ****************
// Link checker
// ****************
module gyro_link_checker #(
   parameter logic [5:0] IDENTITY_CODE = 6'h2a   // Arbitrary value
) (
   input wire logic                CLOCK_I,
   input wire logic                RESETN_I,
   input wire logic                req,
   input wire logic                we,
   input wire gyro_pkg::reg_addr_t addr,
   input wire gyro_pkg::reg_byte_t wdata,
   input wire logic                ack,
   input wire gyro_pkg::reg_byte_t rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // Read and write completions, judged in the ack cycle
   wire rd = ack && !we;
   wire wr = ack && we;
   logic [2:0] stby_q;
   logic [7:0] low_q;
   logic       low_ok_q;
   // Mirror of standby writes and of the shadow low byte; a high read re-arms the shadow
   always_ff @(posedge CLOCK_I) begin
      if (!RESETN_I) begin
         stby_q <= 3'h0;
         low_ok_q <= 1'b0;
      end else begin
         if (wr && addr == 7'h6c) stby_q <= wdata[2:0];
         // A soft reset clears the standby bits and the count shadow
         if (wr && addr == 7'h6b && wdata[7]) begin
            stby_q   <= 3'h0;
            low_ok_q <= 1'b0;
         end
         if (rd && addr == 7'h72) low_ok_q <= 1'b0;
         if (rd && addr == 7'h73) low_ok_q <= 1'b1;
         if (rd && addr == 7'h73) low_q <= rdata;
      end
   end
   a_ack_follows: assert property (req && !ack |=> ack) else $error("ack late");
   a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
   a_ack_cause: assert property (ack |-> $past(req) && !$past(ack)) else $error("stray ack");
   a_rdata_cause: assert property ($changed(rdata) |-> rd) else $error("rdata moved");
   a_ident_code: assert property (
      rd && addr == 7'h75 |-> rdata == {1'b0, IDENTITY_CODE, 1'b0})
      else $error("identity wrong");
   a_count_reserved: assert property (rd && addr == 7'h72 |-> rdata[7:2] == 6'h00)
      else $error("count high reserved set");
   a_standby_back: assert property (rd && addr == 7'h6c |-> rdata[2:0] == stby_q)
      else $error("standby readback");
   a_shadow_kept: assert property (rd && addr == 7'h73 && low_ok_q |-> rdata == low_q)
      else $error("shadow low moved");
   c_ident: cover property (rd && addr == 7'h75);
   c_count: cover property (rd && addr == 7'h72);
   c_standby: cover property (wr && addr == 7'h6c);
endmodule
`default_nettype wire

// file: sim/gyro_standby_fifo_access_regs_test.sv
`default_nettype none
// ****************
// Register bench
// ****************
module gyro_standby_fifo_access_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] ID = 6'h2a;   // Arbitrary value
   logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, err, tick_q = 1'b0, pin = 1'b0, drive, pll;
   logic [63:0] sensor = 64'h8877665544332211;
   logic [2:0] stby;
   logic [6:0] bus_addr;
   int num_errors = 0, total_checks = 0;
   gyro_link_if gyro_link_if_inst();
   gyro_device #(.FIFO_DEPTH(8), .IDENTITY_CODE(ID)) gyro_device_inst (.CLOCK_I(clk),
      .RESETN_I(rstn), .LINK(gyro_link_if_inst), .SAMPLE_TICK_I(tick_q),
      .SENSOR_DATA_I(sensor), .ADDRESS_SELECT_PIN_I(pin), .AXIS_STANDBY_O(stby),
      .DRIVE_ENABLE_O(drive), .PLL_CLOCK_SELECTED_O(pll), .BUS_ADDRESS_O(bus_addr));
   gyro_host gyro_host_inst (.CLOCK_I(clk), .RESETN_I(rstn), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
      .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .LINK(gyro_link_if_inst));
   gyro_link_checker #(.IDENTITY_CODE(ID)) gyro_link_checker_inst (.CLOCK_I(clk),
      .RESETN_I(rstn), .req(gyro_link_if_inst.req), .we(gyro_link_if_inst.we),
      .addr(gyro_link_if_inst.addr), .wdata(gyro_link_if_inst.wdata),
      .ack(gyro_link_if_inst.ack), .rdata(gyro_link_if_inst.rdata));
   // 250 MHz clock
   always #2 clk = ~clk;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; an idle edge after it keeps psel from being driven twice at once
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Register access through the controller: command, then poll done
   task automatic link(input logic w, input gyro_pkg::reg_addr_t a,
                       input gyro_pkg::reg_byte_t d, output gyro_pkg::reg_byte_t q);
      logic [31:0] r;
      apb(1'b1, 12'h000, {15'h0, w, 1'b0, a, d}, r);
      // Poll done with no limit of its own; only the watchdog ends a hang
      do apb(1'b0, 12'h004, 32'h0, r); while (r[1] !== 1'b1);
      q = r[15:8];
   endtask
   task automatic wl(input gyro_pkg::reg_addr_t a, input gyro_pkg::reg_byte_t d);
      gyro_pkg::reg_byte_t q;
      link(1'b1, a, d, q);
   endtask
   task automatic rd(input gyro_pkg::reg_addr_t a, input gyro_pkg::reg_byte_t e);
      gyro_pkg::reg_byte_t q;
      link(1'b0, a, 8'h00, q);
      check(q, e);
   endtask
   // One sample tick, then room for all eight pushes
   task automatic tick();
      tick_q <= 1'b1;
      @(posedge clk);
      tick_q <= 1'b0;
      repeat (12) @(posedge clk);
   endtask
   task automatic t_ident();
      logic [31:0] r;
      rd(7'h75, {1'b0, ID, 1'b0});
      wl(7'h75, 8'hff);
      rd(7'h75, {1'b0, ID, 1'b0});
      pin <= 1'b1;
      repeat (5) @(posedge clk);
      check(bus_addr, {ID, 1'b1});
      apb(1'b0, 12'h008, 32'h0, r);
      check(err, 1'b1);
      $display("identity test done");
   endtask
   task automatic t_standby();
      for (int c = 0; c < 8; c++) begin
         wl(7'h6b, c[7:0]);
         check(pll, c >= 1 && c <= 5);
      end
      wl(7'h6c, 8'hfe);
      check({drive, stby}, 4'b1110);
      rd(7'h6c, 8'h06);
      wl(7'h6c, 8'h07);
      check({drive, stby}, 4'b0111);
      wl(7'h6c, 8'h00);
      check({drive, stby}, 4'b1000);
      // Soft reset drops the standby bits and returns the clock select to its reset code
      wl(7'h6c, 8'h03);
      wl(7'h6b, 8'h80);
      rd(7'h6c, 8'h00);
      check({pll, drive, stby}, 5'b11000);
      wl(7'h6b, 8'h01);
      $display("standby test done");
   endtask
   task automatic t_fifo();
      wl(7'h6a, 8'h40);
      wl(7'h23, 8'h05);
      tick();
      rd(7'h72, 8'h00);
      rd(7'h73, 8'h02);
      rd(7'h74, 8'h11);
      rd(7'h74, 8'h33);
      rd(7'h73, 8'h02);
      wl(7'h74, 8'h5a);
      wl(7'h6a, 8'h00);
      rd(7'h74, 8'h00);
      tick();
      wl(7'h6a, 8'h40);
      rd(7'h72, 8'h00);
      rd(7'h73, 8'h03);
      rd(7'h74, 8'h5a);
      wl(7'h6a, 8'h44);
      rd(7'h6a, 8'h40);
      rd(7'h72, 8'h00);
      rd(7'h73, 8'h00);
      $display("queue test done");
   endtask
   // Two full samples into an eight-byte queue, under each overflow mode
   task automatic t_over();
      gyro_pkg::reg_byte_t q;
      wl(7'h23, 8'hff);
      for (int m = 1; m >= 0; m--) begin
         wl(7'h1a, {1'b0, m[0], 6'h00});
         sensor <= 64'h8877665544332211;
         tick();
         sensor <= 64'h0807060504030201;
         tick();
         link(1'b0, 7'h3a, 8'h00, q);
         check(q[4], 1'b1);
         link(1'b0, 7'h3a, 8'h00, q);
         check(q[4], 1'b0);
         rd(7'h72, 8'h00);
         rd(7'h73, 8'h08);
         rd(7'h74, m ? 8'h11 : 8'h01);
         wl(7'h6a, 8'h44);
      end
      $display("overflow test done");
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Reset for ten cycles, then the scenarios
   initial begin
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_ident();
      t_standby();
      t_fifo();
      t_over();
      results();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (40000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
